// *** rtl/rbs_defines.vh ***
// constants for the reset and supply droop sequencer
`ifndef RBS_DEFINES_VH
`define RBS_DEFINES_VH
// wake-up timer: fixed clock count before release (cycles of core_clk_i)
`define RBS_WAKE_CYCLES 4096
// oscillator must be seen running this many cycles in a row
`define RBS_OSC_STABLE_CYCLES 16
// hysteresis filter: comparator level must hold this many cycles
`define RBS_HYST_CYCLES 8
// address at which the core starts fetching after release
`define RBS_BOOT_ADDR 32'h0000_0000
// width of the wake-up counter
`define RBS_WAKE_W 16
`endif

// *** rtl/rbs_sync_filter.v ***
// three-stage synchroniser with agreement check and hysteresis hold filter
`timescale 1ns/10ps
module rbs_sync_filter #(
    parameter HOLD = 8,             // cycles a new level must persist
    parameter INIT = 1'b1           // level assumed at reset
) (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire async_i,             // raw level from outside the domain
    output reg level_o              // filtered, debounced level
);
    reg s1_r;                       // first stage, read only by s2_r
    reg s2_r;
    reg s3_r;
    reg [7:0] cnt_r;                // persistence counter
    reg [7:0] cnt_nxt;
    reg level_nxt;
    // synchroniser chain
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // a change counts only when stages two and three agree and persist
    always @* begin
        cnt_nxt = 8'h00;
        level_nxt = level_o;
        if ((s2_r == s3_r) && (s3_r != level_o)) begin
            if (cnt_r >= HOLD[7:0] - 8'h01) begin
                level_nxt = s3_r;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end
    // filtered level register
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 8'h00;
            level_o <= INIT;
        end else begin
            cnt_r <= cnt_nxt;
            level_o <= level_nxt;
        end
    end
endmodule

// *** rtl/rbs_reset_seq.v ***
// reset merger, wake-up timer and two-stage supply droop monitor
`timescale 1ns/10ps
`include "rbs_defines.vh"
module rbs_reset_seq #(
    parameter WAKE_CYCLES = `RBS_WAKE_CYCLES,   // fixed count before release
    parameter OSC_CYCLES = `RBS_OSC_STABLE_CYCLES,
    parameter HYST_CYCLES = `RBS_HYST_CYCLES
) (
    input wire core_clk_i,
    input wire rst_b_i,             // power-on detector output, low = reset
    input wire ext_rst_b_i,         // external reset pin, low = reset
    input wire wdt_rst_i,           // watchdog reset request
    input wire droop_warn_i,        // comparator: supply below first level
    input wire droop_rst_i,         // comparator: supply below second level
    input wire osc_ok_i,            // oscillator running indication
    input wire flash_ready_i,       // flash controller init complete
    input wire droop_irq_en_i,      // enable bit from the irq controller
    output reg sys_rst_b_o,         // internal chip reset, low = reset
    output reg [31:0] boot_addr_o,  // first fetch address for the core
    output reg droop_irq_o,         // interrupt line to the irq controller
    output reg droop_status_o,      // polled droop status level
    output reg [3:0] rst_cause_o    // sources seen: pin, wdt, por, droop
);
    localparam ST_HOLD = 3'b001;    // reset held, timer cleared
    localparam ST_WAIT = 3'b010;    // counting and waiting for conditions
    localparam ST_RUN = 3'b100;     // reset released
    wire pin_low;                   // filtered pin, 1 = asserted
    wire pin_lvl;
    wire wdt_lvl;
    wire warn_lvl;
    wire drst_lvl;
    wire osc_lvl;
    wire flash_lvl;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [`RBS_WAKE_W-1:0] wake_cnt_r;
    reg [`RBS_WAKE_W-1:0] wake_cnt_nxt;
    reg [7:0] osc_cnt_r;            // consecutive cycles of running osc
    reg osc_stable_r;
    reg por_seen_r;                 // power-on reset cause, set by rst_b_i, cleared one cycle after its release
    wire rst_req;                   // merged reset request
    wire done;
    wire cause_arm;                 // 1 = state_r not in ST_HOLD, causes logged

    // pin: schmitt-style hysteresis filter, low means reset
    // assumed asserted at power-on, so an early pin low is never lost
    // the hold rejects bounce and noise spikes on the pin
    rbs_sync_filter #(
        .HOLD(HYST_CYCLES),
        .INIT(1'b0)
    ) u_pin (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(ext_rst_b_i),
        .level_o(pin_lvl)
    );
    assign pin_low = ~pin_lvl;      // 1 = pin asks for reset

    // watchdog may tick from its own oscillator, so it is synchronised
    // a one-cycle hold keeps the reset latency short
    // its request must stay up a few cycles to be seen
    rbs_sync_filter #(
        .HOLD(1),
        .INIT(1'b0)
    ) u_wdt (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(wdt_rst_i),
        .level_o(wdt_lvl)
    );

    // first droop stage: the hold stops status chatter near the level
    // a dip shorter than the hold never reaches the core
    // trade-off: a real droop is reported a few cycles late
    rbs_sync_filter #(
        .HOLD(HYST_CYCLES),
        .INIT(1'b0)
    ) u_warn (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(droop_warn_i),
        .level_o(warn_lvl)
    );

    // second droop stage: starts asserted, power-on waits for good supply
    // the hold avoids false chip resets from supply ripple
    // a long droop still resets within a few cycles of the hold
    rbs_sync_filter #(
        .HOLD(HYST_CYCLES),
        .INIT(1'b1)
    ) u_drst (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(droop_rst_i),
        .level_o(drst_lvl)
    );

    // oscillator running flag; stability is judged further down
    // no hold here: any dropout of two cycles or more restarts the judgement at once
    // the flag may come from an analogue detector, hence the synchroniser
    rbs_sync_filter #(
        .HOLD(1),
        .INIT(1'b0)
    ) u_osc (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(osc_ok_i),
        .level_o(osc_lvl)
    );

    // flash controller ready flag
    // its init logic may run from a slower clock, hence the synchroniser
    // no hold needed: the flag only rises once per reset
    rbs_sync_filter #(
        .HOLD(1),
        .INIT(1'b0)
    ) u_flash (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(flash_ready_i),
        .level_o(flash_lvl)
    );

    // merged request; power-on acts through rst_b_i itself
    assign rst_req = pin_low | wdt_lvl | drst_lvl;
    // filters show their reset levels during the power-on hold, not requests
    assign cause_arm = (state_r != ST_HOLD);
    // all release conditions together
    assign done = (wake_cnt_r >= WAKE_CYCLES[`RBS_WAKE_W-1:0] - 1'b1) &&
                  ~pin_low && osc_stable_r && flash_lvl;

    // oscillator stability judge: needs an unbroken run of ok cycles
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_cnt_r <= 8'h00;
            osc_stable_r <= 1'b0;
        end else if (!osc_lvl) begin
            osc_cnt_r <= 8'h00;     // any dropout restarts the judgement
            osc_stable_r <= 1'b0;
        end else if (osc_cnt_r >= OSC_CYCLES[7:0] - 8'h01) begin
            osc_stable_r <= 1'b1;
        end else begin
            osc_cnt_r <= osc_cnt_r + 8'h01;
        end
    end

    // sequencer next state
    always @* begin
        state_nxt = state_r;
        wake_cnt_nxt = wake_cnt_r;
        case (state_r)
            ST_HOLD: begin
                wake_cnt_nxt = {`RBS_WAKE_W{1'b0}};
                if (!rst_req) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rst_req) begin
                    state_nxt = ST_HOLD; // restart timer on new request
                end else if (done) begin
                    state_nxt = ST_RUN;
                end else if (wake_cnt_r < WAKE_CYCLES[`RBS_WAKE_W-1:0] - 1'b1) begin
                    wake_cnt_nxt = wake_cnt_r + 1'b1;
                end
            end
            ST_RUN: begin
                if (rst_req) begin
                    state_nxt = ST_HOLD;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    // sequencer registers; por holds everything via rst_b_i
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_HOLD;
            wake_cnt_r <= {`RBS_WAKE_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            wake_cnt_r <= wake_cnt_nxt;
        end
    end

    // outputs: reset stays low a cycle into run so state settles first
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sys_rst_b_o <= 1'b0;
            boot_addr_o <= `RBS_BOOT_ADDR;
            droop_irq_o <= 1'b0;
            droop_status_o <= 1'b0;
            rst_cause_o <= 4'h0;
            por_seen_r <= 1'b1;
        end else begin
            sys_rst_b_o <= (state_r == ST_RUN) && !rst_req;
            boot_addr_o <= `RBS_BOOT_ADDR;
            droop_status_o <= warn_lvl;
            droop_irq_o <= warn_lvl & droop_irq_en_i;
            por_seen_r <= 1'b0;
            // sticky causes, cleared only by power-on
            // limitation: a source rising while already held is not logged
            rst_cause_o <= rst_cause_o |
                {drst_lvl & cause_arm, por_seen_r, wdt_lvl & cause_arm, pin_low & cause_arm};
        end
    end
endmodule

// *** verif/rbs_core_model.sv ***
// behavioural core and irq controller facing the sequencer
`timescale 1ns/10ps
module rbs_core_model (
    input wire core_clk_i,
    input wire sys_rst_b_i,
    input wire [31:0] boot_addr_i,
    input wire irq_en_set_i,              // software writes the enable bit
    output reg irq_en_o = 1'b0,           // enable bit towards the sequencer
    output reg [31:0] fetch_addr_o = 32'hffff_ffff  // first fetch after release
);
    reg run_r = 1'b0;
    // enable falls to its reset value in reset; a stale fetch must never pass
    always @(posedge core_clk_i) begin
        irq_en_o <= sys_rst_b_i & irq_en_set_i;
        run_r <= sys_rst_b_i;
        if (!sys_rst_b_i) begin
            fetch_addr_o <= 32'hffff_ffff;
        end else if (!run_r) begin
            fetch_addr_o <= boot_addr_i;
        end
    end
endmodule

// *** verif/rbs_reset_seq_properties.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
module rbs_reset_seq_properties #(
    parameter WAKE_CYCLES = 16
) (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire ext_rst_b_i,
    input wire wdt_rst_i,
    input wire droop_warn_i,
    input wire droop_rst_i,
    input wire osc_ok_i,
    input wire flash_ready_i,
    input wire droop_irq_en_i,
    input wire sys_rst_b_o,
    input wire [31:0] boot_addr_o,
    input wire droop_irq_o,
    input wire droop_status_o,
    input wire [3:0] rst_cause_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    reg [15:0] low_cnt_r;  // cycles spent in reset, saturating
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt_r <= 16'h0;
        end else if (sys_rst_b_o) begin
            low_cnt_r <= 16'h0;
        end else if (low_cnt_r != 16'hffff) begin
            low_cnt_r <= low_cnt_r + 16'h1;
        end
    end
    a_boot_addr_zero: assert property (boot_addr_o == 32'h0)
        else $error("boot address not zero");
    a_irq_needs_en: assert property (droop_irq_o |-> $past(droop_irq_en_i))
        else $error("irq without enable");
    a_wdt_forces_rst: assert property (
        $rose(wdt_rst_i) ##1 wdt_rst_i[*3] |-> ##[1:14] !sys_rst_b_o)
        else $error("watchdog did not reset");
    a_pin_forces_rst: assert property (
        $fell(ext_rst_b_i) ##1 !ext_rst_b_i[*8] ##1 !ext_rst_b_i[*8] |-> ##[0:8] !sys_rst_b_o)
        else $error("pin did not reset");
    a_droop_forces_rst: assert property (
        droop_rst_i[*8] ##1 droop_rst_i[*8] |-> !sys_rst_b_o)
        else $error("droop did not reset");
    a_release_conds: assert property (
        $rose(sys_rst_b_o) |-> $past(osc_ok_i, 2) && $past(flash_ready_i, 2) && ext_rst_b_i)
        else $error("release with a condition unmet");
    a_wake_count: assert property ($rose(sys_rst_b_o) |-> low_cnt_r >= WAKE_CYCLES)
        else $error("release before wake count");
    a_status_sets: assert property (
        droop_warn_i[*8] ##1 droop_warn_i[*6] |-> droop_status_o)
        else $error("status missing");
    a_status_clears: assert property (
        !droop_warn_i[*8] ##1 !droop_warn_i[*6] |-> !droop_status_o)
        else $error("status stuck");
    a_cause_sticky: assert property (
        (rst_cause_o & $past(rst_cause_o)) == $past(rst_cause_o))
        else $error("cause bit lost");
endmodule
bind rbs_reset_seq rbs_reset_seq_properties #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.*);

// *** verif/tb_top.sv ***
// self-checking bench for the reset and droop sequencer
`timescale 1ns/10ps
module tb_top;
    reg clk = 0, rst_b = 0, ext_b = 1, wdt = 0, warn = 0, drst = 0, osc = 1, fl = 1, en_set = 0;
    reg ps = 0, ps2 = 0, pt = 0, pt2 = 0;  // delayed reset and status levels
    wire srst_b, irq, stat, en;
    wire [31:0] boot, fetch;
    wire [3:0] cause;
    int mismatches = 0, total_checks = 0, cyc = 0, k, n;
    logic [35:0] expq[$];  // expected results, oldest first
    always #2 clk = ~clk;
    rbs_reset_seq #(.WAKE_CYCLES(16)) DUT (.core_clk_i(clk), .rst_b_i(rst_b), .ext_rst_b_i(ext_b),
        .wdt_rst_i(wdt), .droop_warn_i(warn), .droop_rst_i(drst), .osc_ok_i(osc),
        .flash_ready_i(fl), .droop_irq_en_i(en), .sys_rst_b_o(srst_b), .boot_addr_o(boot),
        .droop_irq_o(irq), .droop_status_o(stat), .rst_cause_o(cause));
    rbs_core_model u_core (.core_clk_i(clk), .sys_rst_b_i(srst_b), .boot_addr_i(boot),
        .irq_en_set_i(en_set), .irq_en_o(en), .fetch_addr_o(fetch));
    task chk(input string nm, input logic [35:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task stop_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task step(input int c);
        repeat (c) @(negedge clk);
    endtask
    // bounded wait for release; a hang ends in a mismatch at the compare
    task wrel;
        for (int i = 0; i < 600 && srst_b !== 1'b1; i++) @(negedge clk);
        step(4);
    endtask
    // watcher: second cycle of release and of status, oldest note wins
    always @(negedge clk) begin
        if (srst_b && ps && !ps2) chk("cause_fetch", {cause, fetch}, expq.pop_front());
        if (stat && pt && !pt2) chk("irq", {35'h0, irq}, expq.pop_front());
        {ps2, ps, pt2, pt} <= {ps, srst_b, pt, stat};
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test;
        end
    end
    initial begin
        n = $urandom(32'h2a90d622);
        expq.push_back({4'b0100, 32'h0});
        step(6);
        rst_b = 1;
        wrel();
        fl = 0;
        wdt = 1;
        step(4);
        wdt = 0;
        step(60);
        chk("flash_hold", srst_b, 0);
        expq.push_back({4'b0110, 32'h0});
        fl = 1;
        wrel();
        osc = 0;
        ext_b = 0;
        step(20 + $urandom % 20);
        ext_b = 1;
        step(60);
        chk("osc_hold", srst_b, 0);
        expq.push_back({4'b0111, 32'h0});
        osc = 1;
        wrel();
        for (k = 0; k < 2; k++) begin
            en_set = k[0];
            warn = 1;
            step(3);
            warn = 0;
            step(15);
            chk("glitch", stat, 0);
            expq.push_back({35'h0, k[0]});
            warn = 1;
            step(20);
            warn = 0;
            step(20);
        end
        drst = 1;
        step(20);
        chk("droop_hold", srst_b, 0);
        expq.push_back({4'b1111, 32'h0});
        drst = 0;
        wrel();
        chk("pending", expq.size(), 0);
        stop_test;
    end
endmodule
